// ### verif/scm_regmove_tb_top.sv
// Self-checking bench for the register-move block, compared with a model each cycle.
// Assumes results show one cycle after issue and inputs settle at the falling edge.
`timescale 1ns/1ns
`default_nettype none

module scm_regmove_tb_top;
    logic        clk_sys, sys_rst, instrValid, intTaken, nextFrameValid;
    logic [15:0] instrWord, accA, accB, accWrData, bound, interruptFrameSnapshot;
    logic [14:0] nextFrame, framePtr, mFp;
    logic        accAWe, accBWe, segmentedCodeModeOff, opDone, stackOverflow;
    logic        mMode, eWa, eWb, eDone, eOvf;
    logic [15:0] mBound, mSnap, eData;
    int          failures = 0;
    int          n_checks = 0;
    int unsigned rng      = 16580;

    scm_regmove dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .instrValid(instrValid),
        .instrWord(instrWord), .accA(accA), .accB(accB), .intTaken(intTaken),
        .nextFrameValid(nextFrameValid), .nextFrame(nextFrame), .accAWe(accAWe),
        .accBWe(accBWe), .accWrData(accWrData), .framePtr(framePtr),
        .segmentedCodeModeOff(segmentedCodeModeOff), .bound(bound),
        .interruptFrameSnapshot(interruptFrameSnapshot), .opDone(opDone),
        .stackOverflow(stackOverflow));

    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    function automatic int unsigned xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction : xs

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic conclude();
        if (failures == 0 && n_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude

    // Called at a falling edge; drives one cycle, then checks at the next falling edge
    task automatic step(input logic v, input logic [15:0] w, input logic it);
        logic [15:0] base, src;
        logic        hit, wr;
        int unsigned r;
        r = xs();
        base = w & ~scm_pkg::ACC_SEL_MASK;
        instrValid = v;
        instrWord = w;
        intTaken = it;
        accA = 16'(xs());
        accB = 16'(xs());
        nextFrameValid = r[0];
        nextFrame = r[1] ? mBound[14:0] + 15'(r[3:2]) - 15'h0002 : 15'(r >> 8);
        src = w[11] ? accB : accA;
        hit = v && base >= scm_pkg::OPC_FROM_FRAME && base <= scm_pkg::OPC_ADD_FRAME;
        if (base == scm_pkg::OPC_ADD_FRAME && it) hit = 1'b0;
        wr = hit && base != scm_pkg::OPC_TO_FRAME && base != scm_pkg::OPC_TO_BOUND;
        eOvf = nextFrameValid && {1'b0, nextFrame} >= mBound;
        // An abandoned add still leaves its sum on the write-back data, with no enable
        if (wr || (v && base == scm_pkg::OPC_ADD_FRAME)) begin
            case (base)
                scm_pkg::OPC_FROM_FRAME: eData = {mMode, mFp};
                scm_pkg::OPC_FROM_BOUND: eData = mBound;
                scm_pkg::OPC_FROM_SNAP:  eData = mSnap;
                default:                 eData = src + {1'b0, mFp};
            endcase
        end
        if (hit && base == scm_pkg::OPC_TO_FRAME) {mMode, mFp} = src;
        if (hit && base == scm_pkg::OPC_TO_BOUND) mBound = src;
        if (it) mSnap = {mMode, mFp};
        eWa = wr && !w[11];
        eWb = wr && w[11];
        eDone = hit;
        @(negedge clk_sys);
        chk("accAWe", 16'(eWa), 16'(accAWe));
        chk("accBWe", 16'(eWb), 16'(accBWe));
        chk("accWrData", eData, accWrData);
        chk("framePtr", 16'(mFp), 16'(framePtr));
        chk("modeOff", 16'(mMode), 16'(segmentedCodeModeOff));
        chk("bound", mBound, bound);
        chk("snapshot", mSnap, interruptFrameSnapshot);
        chk("opDone", 16'(eDone), 16'(opDone));
        chk("stackOverflow", 16'(eOvf), 16'(stackOverflow));
    endtask : step

    // Holds reset for n cycles with the inputs quiet, then checks every output
    task automatic pulse_reset(input int n);
        sys_rst = 1'b1;
        {instrValid, intTaken, nextFrameValid} = 3'h0;
        {mMode, mFp, mBound, mSnap} = {scm_pkg::RST_MODE_OFF, scm_pkg::RST_FRAME,
            scm_pkg::RST_BOUND, scm_pkg::RST_SNAP};
        {eData, eWa, eWb, eDone, eOvf} = 20'h00000;
        repeat (n) @(negedge clk_sys);
        sys_rst = 1'b0;
        chk("rstFrame", 16'(mFp), 16'(framePtr));
        chk("rstModeOff", 16'(mMode), 16'(segmentedCodeModeOff));
        chk("rstBound", mBound, bound);
        chk("rstSnap", mSnap, interruptFrameSnapshot);
        chk("rstData", eData, accWrData);
        chk("rstWe", 16'({eWa, eWb}), 16'({accAWe, accBWe}));
        chk("rstDone", 16'(eDone), 16'(opDone));
        chk("rstOvf", 16'(eOvf), 16'(stackOverflow));
    endtask : pulse_reset

    initial begin
        logic [15:0] w;
        int unsigned r;
        {instrWord, accA, accB} = 48'h0;
        nextFrame = 15'h0000;
        pulse_reset(8);
        // Every opcode in both forms, back to back, then refused cases
        for (int i = 0; i < 12; i++) begin
            step(1'b1, (scm_pkg::OPC_FROM_FRAME + 16'(i % 6)) |
                 (i >= 6 ? scm_pkg::ACC_SEL_MASK : 16'h0000), 1'b0);
        end
        step(1'b1, scm_pkg::OPC_ADD_FRAME, 1'b1);
        step(1'b1, scm_pkg::OPC_ADD_FRAME | scm_pkg::ACC_SEL_MASK, 1'b1);
        step(1'b1, 16'h830c, 1'b0);
        step(1'b0, scm_pkg::OPC_TO_FRAME, 1'b0);
        // Reset again mid-run, then read the frame word straight back
        pulse_reset(2);
        step(1'b1, scm_pkg::OPC_FROM_FRAME, 1'b0);
        for (int i = 0; i < 600; i++) begin
            r = xs();
            w = (scm_pkg::OPC_FROM_FRAME + 16'(r % 6)) | (r[8] ? scm_pkg::ACC_SEL_MASK : 16'h0);
            if (r[12:9] == 4'h0) w = 16'(r >> 16);
            step(r[13:10] != 4'h0, w, r[14] & r[15]);
        end
        conclude();
    end
endmodule : scm_regmove_tb_top

`default_nettype wire

// ### verilog/scm_decode.sv
// Opcode decoder for the register-move group.
// Assumes the instruction word is stable while instrValid is high.
`timescale 1ns/1ns
`default_nettype none

module scm_decode (
    input  wire logic [15:0]       instrWord,
    input  wire logic              instrValid,
    output scm_pkg::scm_dec_s      dec
);

    // Fold both accumulator forms onto the A form
    wire logic [15:0] baseWord = instrWord & ~scm_pkg::ACC_SEL_MASK;
    wire logic        isToFrame   = baseWord == scm_pkg::OPC_TO_FRAME;
    wire logic        isFromFrame = baseWord == scm_pkg::OPC_FROM_FRAME;
    wire logic        isToBound   = baseWord == scm_pkg::OPC_TO_BOUND;
    wire logic        isFromBound = baseWord == scm_pkg::OPC_FROM_BOUND;
    wire logic        isFromSnap  = baseWord == scm_pkg::OPC_FROM_SNAP;
    wire logic        isAddFrame  = baseWord == scm_pkg::OPC_ADD_FRAME;

    wire scm_pkg::scm_op_e opSel =
        !instrValid ? scm_pkg::OP_NONE       :
        isToFrame   ? scm_pkg::OP_TO_FRAME   :
        isFromFrame ? scm_pkg::OP_FROM_FRAME :
        isToBound   ? scm_pkg::OP_TO_BOUND   :
        isFromBound ? scm_pkg::OP_FROM_BOUND :
        isFromSnap  ? scm_pkg::OP_FROM_SNAP  :
        isAddFrame  ? scm_pkg::OP_ADD_FRAME  : scm_pkg::OP_NONE; // see (RULE15)

    assign dec.op   = opSel;
    assign dec.useB = instrWord[scm_pkg::ACC_SEL_BIT];

endmodule : scm_decode

`default_nettype wire

// ### verilog/scm_pkg.sv
// Shared constants and types for the segmented-code register-move logic.
// Assumes a 16-bit datapath with two accumulators outside this block.
package scm_pkg;

    localparam int          DATA_W         = 16;
    localparam int          FRAME_W        = 15;
    localparam int          MODE_BIT       = 15;
    localparam int          ACC_SEL_BIT    = 11;
    localparam logic [15:0] ACC_SEL_MASK   = 16'h0800;

    // Opcodes with the accumulator-select bit clear (A form)
    localparam logic [15:0] OPC_TO_FRAME   = 16'h8307;
    localparam logic [15:0] OPC_FROM_FRAME = 16'h8306;
    localparam logic [15:0] OPC_TO_BOUND   = 16'h8309;
    localparam logic [15:0] OPC_FROM_BOUND = 16'h8308;
    localparam logic [15:0] OPC_FROM_SNAP  = 16'h830a;
    localparam logic [15:0] OPC_ADD_FRAME  = 16'h830b;

    // Reset values
    localparam logic [14:0] RST_FRAME      = 15'h0000;
    localparam logic        RST_MODE_OFF   = 1'h1;
    localparam logic [15:0] RST_BOUND      = 16'h7fff;
    localparam logic [15:0] RST_SNAP       = 16'h8000;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_TO_FRAME,
        OP_FROM_FRAME,
        OP_TO_BOUND,
        OP_FROM_BOUND,
        OP_FROM_SNAP,
        OP_ADD_FRAME
    } scm_op_e;

    typedef struct packed {
        scm_op_e op;
        logic    useB;
    } scm_dec_s;

endpackage : scm_pkg

// ### verilog/scm_regmove.sv
// Execution logic for the frame, bound and snapshot register moves.
// Assumes the datapath presents both accumulators, writes back on accAWe/accBWe
// one cycle after issue, and pulses intTaken when an interrupt or fault is taken.
`timescale 1ns/1ns
`default_nettype none

// Notes on behaviour
// (RULE1) Copy A to frame loads the frame pointer from A[14:0] and the mode flag from A[15].
// (RULE2) Copy B to frame loads the frame pointer from B[14:0] and the mode flag from B[15].
// (RULE3) Copy frame to A gives A the frame pointer low and the mode flag in bit 15.
// (RULE4) Copy frame to B gives B the frame pointer low and the mode flag in bit 15.
// (RULE5) Copy A to bound writes all sixteen bits of A into the bound register.
// (RULE6) Copy B to bound writes all sixteen bits of B into the bound register.
// (RULE7) Copy bound to A loads A with the whole bound register.
// (RULE8) Copy bound to B loads B with the whole bound register.
// (RULE9) Copy snapshot to A loads A with the interrupt snapshot.
// (RULE10) Copy snapshot to B loads B with the interrupt snapshot.
// (RULE11) Taking an interrupt or fault captures mode flag and frame pointer into the snapshot.
// (RULE12) Add frame to A replaces A with A plus the frame pointer and may be interrupted.
// (RULE13) Add frame to B replaces B with B plus the frame pointer and may be interrupted.
// (RULE14) A next-frame pointer at or above the bound flags stack overflow for memory protect.
// (RULE15) The twelve opcodes are decoded exactly and each copy completes without interruption.
module scm_regmove (
    input  wire logic              clk_sys,
    input  wire logic              sys_rst,
    input  wire logic              instrValid,
    input  wire logic [15:0]       instrWord,
    input  wire logic [15:0]       accA,
    input  wire logic [15:0]       accB,
    input  wire logic              intTaken,
    input  wire logic              nextFrameValid,
    input  wire logic [14:0]       nextFrame,
    output logic                   accAWe,
    output logic                   accBWe,
    output logic [15:0]            accWrData,
    output logic [14:0]            framePtr,
    output logic                   segmentedCodeModeOff,
    output logic [15:0]            bound,
    output logic [15:0]            interruptFrameSnapshot,
    output logic                   opDone,
    output logic                   stackOverflow
);

    scm_pkg::scm_dec_s dec;

    scm_decode u_decode (
        .instrWord  (instrWord),
        .instrValid (instrValid),
        .dec        (dec)
    );

    wire logic [15:0] srcAcc     = dec.useB ? accB : accA;
    wire logic [15:0] frameWord  = {segmentedCodeModeOff, framePtr};
    wire logic [15:0] frameSum   = 16'(srcAcc + {1'b0, framePtr});

    wire logic isToFrame   = dec.op == scm_pkg::OP_TO_FRAME;
    wire logic isFromFrame = dec.op == scm_pkg::OP_FROM_FRAME;
    wire logic isToBound   = dec.op == scm_pkg::OP_TO_BOUND;
    wire logic isFromBound = dec.op == scm_pkg::OP_FROM_BOUND;
    wire logic isFromSnap  = dec.op == scm_pkg::OP_FROM_SNAP;
    wire logic isAdd       = dec.op == scm_pkg::OP_ADD_FRAME;

    // The add is the only interruptible one: an interrupt in its cycle abandons it
    wire logic addAbort  = isAdd && intTaken; // see (RULE12) (RULE13)
    wire logic accWrite  = isFromFrame || isFromBound || isFromSnap || (isAdd && !intTaken);

    // Mode flag high means segmented-code mode is off
    wire logic [14:0] next_framePtr = isToFrame ? srcAcc[14:0] : framePtr; // see (RULE1) (RULE2)
    wire logic        next_modeOff  = isToFrame ? srcAcc[scm_pkg::MODE_BIT]
                                                : segmentedCodeModeOff; // see (RULE1) (RULE2)
    wire logic [15:0] next_bound    = isToBound ? srcAcc : bound; // see (RULE5) (RULE6)

    wire logic [15:0] next_accWrData =
        isFromFrame ? frameWord :                // see (RULE3) (RULE4)
        isFromBound ? bound :                    // see (RULE7) (RULE8)
        isFromSnap  ? interruptFrameSnapshot :   // see (RULE9) (RULE10)
        isAdd       ? frameSum : accWrData;      // see (RULE12) (RULE13)

    // A copy finishing in the interrupt cycle is seen whole by the snapshot
    wire logic [15:0] next_snapshot = intTaken ? {next_modeOff, next_framePtr}
                                               : interruptFrameSnapshot; // see (RULE11) (RULE15)

    // Bit 15 of the bound is treated as data; a set bit puts the limit above every next-frame pointer
    wire logic next_overflow = nextFrameValid && ({1'b0, nextFrame} >= bound); // see (RULE14)

    wire logic next_accAWe = accWrite && !dec.useB;
    wire logic next_accBWe = accWrite && dec.useB;
    wire logic next_opDone = (dec.op != scm_pkg::OP_NONE) && !addAbort; // see (RULE15)

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            framePtr             <= scm_pkg::RST_FRAME;
            segmentedCodeModeOff <= scm_pkg::RST_MODE_OFF;
        end else begin
            framePtr             <= next_framePtr;
            segmentedCodeModeOff <= next_modeOff;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            bound <= scm_pkg::RST_BOUND;
        end else begin
            bound <= next_bound;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            interruptFrameSnapshot <= scm_pkg::RST_SNAP;
        end else begin
            interruptFrameSnapshot <= next_snapshot;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            accWrData <= 16'h0000;
            accAWe    <= 1'h0;
            accBWe    <= 1'h0;
            opDone    <= 1'h0;
        end else begin
            accWrData <= next_accWrData;
            accAWe    <= next_accAWe;
            accBWe    <= next_accBWe;
            opDone    <= next_opDone;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (sys_rst) begin
            stackOverflow <= 1'h0;
        end else begin
            stackOverflow <= next_overflow;
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (sys_rst);

    toFrame_load_a: assert property (isToFrame |=> // see (RULE1) (RULE2)
        framePtr == $past(srcAcc[14:0]) && segmentedCodeModeOff == $past(srcAcc[15]))
        else $error("frame copy did not load pointer and mode");

    fromFrame_read_a: assert property (isFromFrame |=> // see (RULE3) (RULE4)
        (accAWe ^ accBWe) && accWrData == {$past(segmentedCodeModeOff), $past(framePtr)})
        else $error("frame read gave wrong accumulator value");

    toBound_write_a: assert property (isToBound |=> bound == $past(srcAcc)) // see (RULE5) (RULE6)
        else $error("bound not loaded from accumulator");

    fromBound_read_a: assert property (isFromBound |=> // see (RULE7) (RULE8)
        accWrData == $past(bound) && accBWe == $past(dec.useB))
        else $error("bound read gave wrong value or target");

    fromSnap_read_a: assert property (isFromSnap |=> // see (RULE9) (RULE10)
        accWrData == $past(interruptFrameSnapshot) && (accAWe || accBWe))
        else $error("snapshot read gave wrong value");

    snap_capture_a: assert property (intTaken && !isToFrame |=> // see (RULE11)
        interruptFrameSnapshot == {segmentedCodeModeOff, framePtr})
        else $error("snapshot missed mode and frame pointer");

    snap_hold_a: assert property (!intTaken |=> $stable(interruptFrameSnapshot)) // see (RULE11)
        else $error("snapshot changed without interrupt");

    add_frame_a: assert property (isAdd && !intTaken |=> // see (RULE12) (RULE13)
        accWrData == 16'($past(srcAcc) + {1'b0, $past(framePtr)}) && (accAWe ^ accBWe))
        else $error("add result wrong");

    add_abort_a: assert property (isAdd && intTaken |=> !accAWe && !accBWe && !opDone) // see (RULE12)
        else $error("interrupted add wrote back");

    overflow_flag_a: assert property (nextFrameValid |=> // see (RULE14)
        stackOverflow == ({1'b0, $past(nextFrame)} >= $past(bound)))
        else $error("stack overflow flag wrong");

    copy_atomic_a: assert property (isToFrame && intTaken |=> // see (RULE15)
        interruptFrameSnapshot == {segmentedCodeModeOff, framePtr})
        else $error("interrupt split a frame copy");

    illegal_idle_a: assert property (instrValid && dec.op == scm_pkg::OP_NONE |=> // see (RULE15)
        !opDone && !accAWe && !accBWe)
        else $error("unknown opcode had an effect");

    frame_hold_a: assert property (!isToFrame |=> // see (RULE1) (RULE2)
        $stable(framePtr) && $stable(segmentedCodeModeOff))
        else $error("frame pointer or mode changed without a frame copy");

    bound_hold_a: assert property (!isToBound |=> $stable(bound)) // see (RULE5) (RULE6)
        else $error("bound changed without a bound copy");

    write_onehot_a: assert property (!(accAWe && accBWe)) // see (RULE15)
        else $error("both accumulators written at once");

    write_target_a: assert property ( // see (RULE3) (RULE4) (RULE9) (RULE10)
        isFromFrame || isFromSnap || (isAdd && !intTaken) |=>
        accBWe == $past(dec.useB) && accAWe == !$past(dec.useB))
        else $error("write-back went to the wrong accumulator");

    data_hold_a: assert property ( // see (RULE15)
        !(isFromFrame || isFromBound || isFromSnap || isAdd) |=> $stable(accWrData))
        else $error("write-back data changed with nothing to write");

    overflow_idle_a: assert property (!nextFrameValid |=> !stackOverflow) // see (RULE14)
        else $error("stack overflow raised with no pointer to check");

    idle_quiet_a: assert property (!instrValid |=> !opDone && !accAWe && !accBWe) // see (RULE15)
        else $error("activity without an instruction");

    store_nowrite_a: assert property (isToFrame || isToBound |=> // see (RULE1) (RULE5)
        !accAWe && !accBWe)
        else $error("register store wrote an accumulator");

    copy_complete_a: assert property ( // see (RULE15)
        dec.op != scm_pkg::OP_NONE && !isAdd |=> opDone)
        else $error("copy did not complete");

    add_done_a: assert property (isAdd && !intTaken |=> opDone) // see (RULE12) (RULE13)
        else $error("add did not complete");

    cov_toFrame_c:  cover property (isToFrame ##1 isFromFrame);
    cov_addAbort_c: cover property (isAdd && intTaken);
    cov_overflow_c: cover property (stackOverflow);
    cov_snapRead_c: cover property (intTaken ##[1:4] isFromSnap);
    cov_addB_c:     cover property (isAdd && dec.useB && !intTaken);

endmodule : scm_regmove

`default_nettype wire
